// File: src/angsp_top.sv
// Module: SPI mode 3 slave with configuration registers and angle stream
// Assumes: external SPI master supplies sclk; fuse contents valid at reset release
// Contract
// - Slave only, never drives serial clock
// - Sixteen bits in and out per frame
// - Mode 3, rising sample, MSB first
// - Hold eight-bit bias trim amount
// - Hold zero offset, 360/256 degree step
// - X enable reduces X bias current
// - Y enable reduces Y bias current
// - Both enables reduce both equally
// - Lowest set flash request bit n burns register n
// - Front end refreshes angle at 500kHz
// - Angle from time-to-digital phase counter
// - Angle rises with clockwise rotation
// - Write is 0010, address, value
// - Read is 0001, address, don't-care
// - Read returns angle then register byte
// - Reset loads zero or fuse, locks
`timescale 1ns/1ps
`default_nettype none
module angsp_top
	import angsp_pkg::*;
(
	// System clock and control
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// SPI link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso = 1'b0,
	output logic miso_oe = 1'b0,
	// Front end
	input wire logic sine_sign,
	// Fuse array
	input wire logic [31:0] fuse_values,
	input wire logic [3:0] fuse_blown,
	output logic [7:0] fuse_burn_data,
	output logic [3:0] fuse_burn_sel,
	output logic fuse_burn_strobe,
	// Analog trim outputs
	output angsp_bias_t bias_reduction
);
	// Link-side (sclk) state
	logic [15:0] rx_sr_q;
	logic [15:0] tx_sr_q;
	logic [4:0] bit_cnt_q = BIT_COUNT_RESET;
	logic [7:0] rd_data_q = 8'h00;
	logic cmd_tgl_q = 1'b0;
	angsp_word_t cmd_word_q = '0;
	logic [7:0] angle_hold_q;
	logic [7:0] angle_lk1_q;
	logic [7:0] angle_lk2_q;
	logic [7:0] reg_lk1_q [0:15];
	logic [7:0] reg_lk2_q [0:15];

	// System-side state
	angsp_cfg_t cfg_q;
	logic [3:0] lock_q;
	logic [2:0] tgl_s_q;
	logic [15:0] word_s1_q;
	logic cmd_pulse_q;
	logic [1:0] sine_s_q;
	logic [7:0] angle_q;
	logic [7:0] angle_pub_q;
	logic [7:0] regs_pub_q [0:15];
	logic angle_valid;
	logic [7:0] angle_raw;
	angsp_word_t sys_word;
	logic cmd_pulse;

	typedef enum {ST_IDLE, ST_BURN} angsp_state_t;
	angsp_state_t state_q;

	function automatic logic [7:0] reg_read(input angsp_cfg_t c, input logic [3:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			ADDR_BIAS_TRIM: r = c.bias_trim_amount;
			ADDR_ZERO_OFFSET: r = c.zero_offset;
			ADDR_AXIS_TRIM: r = c.axis_trim_enables & AXIS_TRIM_MASK;
			ADDR_FUSE_FLASH: r = c.fuse_flash_request & FUSE_FLASH_MASK;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	function automatic int lock_index(input logic [3:0] a);
		int i;
		i = 0;
		case (a)
			ADDR_BIAS_TRIM: i = 0;
			ADDR_ZERO_OFFSET: i = 1;
			ADDR_AXIS_TRIM: i = 2;
			default: i = 3;
		endcase
		return i;
	endfunction

	// Front end
	always_ff @(posedge clk) begin
		if (srst) begin
			sine_s_q <= 2'b00;
		end else if (ce) begin
			sine_s_q <= {sine_s_q[0], sine_sign};
		end
	end

	angsp_tdc u_tdc (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.sine_sign(sine_s_q[1]),
		.zero_offset(cfg_q.zero_offset),
		.angle(angle_raw),
		.angle_valid(angle_valid)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			angle_q <= 8'h00;
		end else if (ce && angle_valid) begin
			angle_q <= angle_raw;
		end
	end

	// Command toggle synchroniser; not reset so no false edge
	always_ff @(posedge clk) begin
		if (ce) begin
			tgl_s_q <= {tgl_s_q[1:0], cmd_tgl_q};
		end
	end

	// Word captured once stable, qualified by the toggle edge
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_pulse_q <= 1'b0;
			word_s1_q <= 16'h0000;
		end else if (ce) begin
			cmd_pulse_q <= tgl_s_q[2] ^ tgl_s_q[1];
			if (tgl_s_q[2] ^ tgl_s_q[1]) begin
				word_s1_q <= cmd_word_q;
			end
		end
	end
	assign cmd_pulse = cmd_pulse_q;
	assign sys_word = word_s1_q;

	// Configuration registers, fuse load and lock
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_q <= {4{REG_RESET}};
			lock_q <= 4'h0;
			state_q <= ST_IDLE;
		end else if (ce) begin
			if (lock_q == 4'h0 && state_q == ST_IDLE && fuse_blown != 4'h0 && !cmd_pulse) begin
				// Post-release fuse load
				lock_q <= fuse_blown;
				if (fuse_blown[0]) cfg_q.bias_trim_amount <= fuse_values[31:24];
				if (fuse_blown[1]) cfg_q.zero_offset <= fuse_values[23:16];
				if (fuse_blown[2]) cfg_q.axis_trim_enables <= fuse_values[15:8] & AXIS_TRIM_MASK;
				if (fuse_blown[3]) cfg_q.fuse_flash_request <= fuse_values[7:0] & FUSE_FLASH_MASK;
			end else if (cmd_pulse && sys_word.cmd == CMD_WRITE &&
				!lock_q[lock_index(sys_word.addr)]) begin
				case (sys_word.addr)
					ADDR_BIAS_TRIM: cfg_q.bias_trim_amount <= sys_word.value;
					ADDR_ZERO_OFFSET: cfg_q.zero_offset <= sys_word.value;
					ADDR_AXIS_TRIM: cfg_q.axis_trim_enables <= sys_word.value & AXIS_TRIM_MASK;
					ADDR_FUSE_FLASH: begin
						cfg_q.fuse_flash_request <= sys_word.value & FUSE_FLASH_MASK;
						state_q <= ST_BURN;
					end
					default: cfg_q <= cfg_q;
				endcase
			end else begin
				case (state_q)
					ST_BURN: state_q <= ST_IDLE;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Fuse burn request, one register at a time
	always_ff @(posedge clk) begin
		if (srst) begin
			fuse_burn_data <= 8'h00;
			fuse_burn_sel <= 4'h0;
			fuse_burn_strobe <= 1'b0;
		end else if (ce) begin
			fuse_burn_strobe <= 1'b0;
			if (state_q == ST_BURN) begin
				fuse_burn_strobe <= 1'b1;
				fuse_burn_sel <= 4'h0;
				if (cfg_q.fuse_flash_request[FUSE_FIRST_REG]) begin
					fuse_burn_sel <= 4'h1;
					fuse_burn_data <= cfg_q.bias_trim_amount;
				end else if (cfg_q.fuse_flash_request[FUSE_FIRST_REG + 1]) begin
					fuse_burn_sel <= 4'h2;
					fuse_burn_data <= cfg_q.zero_offset;
				end else if (cfg_q.fuse_flash_request[FUSE_FIRST_REG + 2]) begin
					fuse_burn_sel <= 4'h4;
					fuse_burn_data <= cfg_q.axis_trim_enables;
				end else begin
					fuse_burn_strobe <= 1'b0;
				end
			end
		end
	end

	// Axis bias reduction
	always_ff @(posedge clk) begin
		if (srst) begin
			bias_reduction <= '0;
		end else if (ce) begin
			// Both set gives equal reduction, no side-shaft correction
			bias_reduction.x_reduction <= cfg_q.axis_trim_enables[AXIS_X_BIT] ?
				cfg_q.bias_trim_amount : 8'h00;
			bias_reduction.y_reduction <= cfg_q.axis_trim_enables[AXIS_Y_BIT] ?
				cfg_q.bias_trim_amount : 8'h00;
		end
	end

	// Publish stable snapshots for the link domain
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_pub
			always_ff @(posedge clk) begin
				if (srst) begin
					regs_pub_q[g] <= 8'h00;
				end else if (ce) begin
					regs_pub_q[g] <= reg_read(cfg_q, 4'(g));
				end
			end
			always_ff @(posedge sclk) begin
				reg_lk1_q[g] <= regs_pub_q[g];
				reg_lk2_q[g] <= reg_lk1_q[g];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			angle_pub_q <= 8'h00;
		end else if (ce) begin
			angle_pub_q <= angle_q;
		end
	end

	// Link domain: slave only, sclk comes from the master
	always_ff @(posedge sclk) begin
		angle_lk1_q <= angle_pub_q;
		angle_lk2_q <= angle_lk1_q;
	end

	// Receive on rising edge, MSB first
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_q <= BIT_COUNT_RESET;
			rx_sr_q <= 16'h0000;
		end else begin
			rx_sr_q <= {rx_sr_q[14:0], mosi};
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// Full word latched; read data fetched after the address byte
	always_ff @(posedge sclk) begin
		if (!cs_n) begin
			if (bit_cnt_q == 5'h07) begin
				rd_data_q <= (rx_sr_q[6:3] == CMD_READ) ?
					reg_lk2_q[{rx_sr_q[2:0], mosi}] : angle_hold_q;
			end
			if (bit_cnt_q == 5'h0F) begin
				cmd_word_q <= {rx_sr_q[14:0], mosi};
				cmd_tgl_q <= ~cmd_tgl_q;
			end
		end
	end

	// Transmit on falling edge; angle frozen at the first falling edge of the frame
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_sr_q <= 16'h0000;
			angle_hold_q <= 8'h00;
		end else if (bit_cnt_q == 5'h00) begin
			angle_hold_q <= angle_lk2_q;
			tx_sr_q <= {angle_lk2_q[6:0], 9'h000};
		end else if (bit_cnt_q == 5'h08) begin
			tx_sr_q <= {rd_data_q[6:0], 9'h000};
		end else begin
			tx_sr_q <= {tx_sr_q[14:0], 1'b0};
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= 1'b1;
			miso <= (bit_cnt_q == 5'h00) ? angle_lk2_q[7] :
				(bit_cnt_q == 5'h08) ? rd_data_q[7] : tx_sr_q[15];
		end
	end
endmodule
`default_nettype wire

// File: include/angsp_pkg.sv
// Package: constants and types for the angle sensor SPI and configuration block
// Assumes: included before all design files of the block
package angsp_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int WORD_BITS = 16;
	localparam logic [3:0] CMD_READ = 4'h1;
	localparam logic [3:0] CMD_WRITE = 4'h2;
	localparam logic [3:0] ADDR_BIAS_TRIM = 4'h3;
	localparam logic [3:0] ADDR_ZERO_OFFSET = 4'h4;
	localparam logic [3:0] ADDR_AXIS_TRIM = 4'h5;
	localparam logic [3:0] ADDR_FUSE_FLASH = 4'h9;
	localparam int AXIS_X_BIT = 4;
	localparam int AXIS_Y_BIT = 5;
	localparam logic [7:0] AXIS_TRIM_MASK = 8'h30;
	localparam logic [7:0] FUSE_FLASH_MASK = 8'h38;
	localparam int FUSE_FIRST_REG = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int REFRESH_HZ = 500000;
	localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;
	localparam int PHASE_BITS = 8;
	localparam logic [4:0] BIT_COUNT_RESET = 5'h00;

	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [7:0] value;
	} angsp_word_t;

	typedef struct packed {
		logic [7:0] bias_trim_amount;
		logic [7:0] zero_offset;
		logic [7:0] axis_trim_enables;
		logic [7:0] fuse_flash_request;
	} angsp_cfg_t;

	typedef struct packed {
		logic [7:0] x_reduction;
		logic [7:0] y_reduction;
	} angsp_bias_t;
endpackage

// File: src/angsp_tdc.sv
// Module: time-to-digital angle front end
// Assumes: sine zero crossing arrives as a synchronised level on clk
`timescale 1ns/1ps
`default_nettype none
module angsp_tdc
	import angsp_pkg::*;
(
	// Clock and control
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Phase inputs
	input wire logic sine_sign,
	input wire logic [7:0] zero_offset,
	// Angle output
	output logic [7:0] angle,
	output logic angle_valid
);
	logic [7:0] ref_cnt_q;
	logic [7:0] phase_q;
	logic sign_q;
	logic [$clog2(REFRESH_CYCLES)-1:0] rate_q;

	// Reference waveform counter; its wrap is the constant edge
	always_ff @(posedge clk) begin
		if (srst) begin
			ref_cnt_q <= 8'h00;
			sign_q <= 1'b0;
			phase_q <= 8'h00;
		end else if (ce) begin
			ref_cnt_q <= ref_cnt_q + 8'h01;
			sign_q <= sine_sign;
			if (sine_sign && !sign_q) begin
				phase_q <= ref_cnt_q;
			end
		end
	end

	// Open-loop refresh at fixed rate
	always_ff @(posedge clk) begin
		if (srst) begin
			rate_q <= '0;
			angle <= 8'h00;
			angle_valid <= 1'b0;
		end else if (ce) begin
			angle_valid <= 1'b0;
			if (rate_q == ($clog2(REFRESH_CYCLES))'(REFRESH_CYCLES - 1)) begin
				rate_q <= '0;
				// Count rises with clockwise field rotation
				angle <= phase_q - zero_offset;
				angle_valid <= 1'b1;
			end else begin
				rate_q <= rate_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/angsp_chk.sv
// Checker: port-level properties of the angle sensor SPI block
// Assumes: bound to angsp_top, link has no reset of its own
`timescale 1ns/1ps
`default_nettype none
module angsp_chk
	import angsp_pkg::*;
(
	// Clocks and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	// SPI link
	input wire logic cs_n,
	input wire logic miso_oe,
	// Fuse and trim
	input wire logic [3:0] fuse_burn_sel,
	input wire logic fuse_burn_strobe,
	input wire angsp_bias_t bias_reduction
);
	property p_oe_idle;
		@(posedge clk) disable iff (srst) cs_n && $past(cs_n) |-> !miso_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
	property p_oe_frame;
		@(posedge sclk) disable iff (cs_n) 1'b1 |-> miso_oe;
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("miso not driven in frame");
	property p_burn_pulse;
		@(posedge clk) disable iff (srst) fuse_burn_strobe |=> !fuse_burn_strobe;
	endproperty
	a_burn_pulse: assert property (p_burn_pulse) else $error("burn strobe too long");
	property p_burn_sel;
		@(posedge clk) disable iff (srst) fuse_burn_strobe |-> $onehot(fuse_burn_sel[2:0]) && !fuse_burn_sel[3];
	endproperty
	a_burn_sel: assert property (p_burn_sel) else $error("burn select not one-hot");
	property p_bias_equal;
		@(posedge clk) disable iff (srst)
		bias_reduction.x_reduction != 8'h00 && bias_reduction.y_reduction != 8'h00
		|-> bias_reduction.x_reduction == bias_reduction.y_reduction;
	endproperty
	a_bias_equal: assert property (p_bias_equal) else $error("axis reductions differ");
	property p_rst_bias;
		@(posedge clk) disable iff (srst) $past(srst) |-> bias_reduction == 16'h0000;
	endproperty
	a_rst_bias: assert property (p_rst_bias) else $error("bias not cleared by reset");
	property p_rst_burn;
		@(posedge clk) disable iff (srst) $past(srst) |-> !fuse_burn_strobe && fuse_burn_sel == 4'h0;
	endproperty
	a_rst_burn: assert property (p_rst_burn) else $error("burn active after reset");
	property p_bias_stable;
		@(posedge clk) disable iff (srst) (cs_n && !srst) [*8] |=> $stable(bias_reduction);
	endproperty
	a_bias_stable: assert property (p_bias_stable) else $error("bias changed while idle");
endmodule
bind angsp_top angsp_chk u_chk (.clk, .srst, .sclk, .cs_n, .miso_oe, .fuse_burn_sel, .fuse_burn_strobe,
	.bias_reduction);
`default_nettype wire

// File: tb/angsp_master.sv
// Partner: mode 3 SPI master on its own 15 ns link clock
// Assumes: bench calls xfer one frame at a time
`timescale 1ns/1ps
`default_nettype none
module angsp_master (
	// SPI link
	output logic sclk = 1'b1,
	output logic cs_n = 1'b1,
	output logic mosi = 1'b0,
	input wire logic miso,
	input wire logic miso_oe
);
	logic lclk = 1'b0;
	always #7.5 lclk = ~lclk;
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge lclk);
		cs_n <= 1'b0;
		repeat (4) @(posedge lclk);
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b0;
			mosi <= tx[i];
			repeat (2) @(posedge lclk);
			sclk <= 1'b1;
			rx[i] = miso_oe ? miso : ~miso;
			repeat (2) @(posedge lclk);
		end
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (4) @(posedge lclk);
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Testbench: register, trim, flash and fuse lock checks
// Assumes: angsp_top and the master model compiled before
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import angsp_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic sine_sign = 1'b0;
	logic [31:0] fuse_values = 32'h00000000;
	logic [3:0] fuse_blown = 4'h0;
	logic sclk, cs_n, mosi, miso, miso_oe, fbst;
	logic [7:0] fbd, r3, r4, r5, v;
	logic [3:0] fbs;
	logic [15:0] rx;
	angsp_bias_t bias;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end
	always @(posedge clk) #1 sine_sign <= cyc[3] ^ cyc[5];
	angsp_top u_dut (.clk(clk), .srst(srst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .sine_sign(sine_sign), .fuse_values(fuse_values), .fuse_blown(fuse_blown),
		.fuse_burn_data(fbd), .fuse_burn_sel(fbs), .fuse_burn_strobe(fbst), .bias_reduction(bias));
	angsp_master u_mst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
	task end_of_test();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] msk(input logic [3:0] a, input logic [7:0] d);
		case (a)
			ADDR_BIAS_TRIM, ADDR_ZERO_OFFSET: return d;
			ADDR_AXIS_TRIM: return d & AXIS_TRIM_MASK;
			ADDR_FUSE_FLASH: return d & FUSE_FLASH_MASK;
			default: return 8'h00;
		endcase
	endfunction
	task rst();
		@(posedge clk) #1 srst = 1'b1;
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		repeat (30) @(posedge clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		u_mst.xfer({CMD_WRITE, a, d}, rx);
		repeat (12) @(posedge clk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		u_mst.xfer({CMD_READ, a, 8'h00}, rx);
		chk({8'h00, rx[7:0]}, {8'h00, e});
	endtask
	task burn(input logic [3:0] s, input logic [7:0] d);
		int n;
		n = 0;
		while (fbst !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, fbst}, 16'h0001);
		chk({12'h000, fbs}, {12'h000, s});
		chk({8'h00, fbd}, {8'h00, d});
	endtask
	initial begin
		v = 8'($urandom(48857));
		rst();
		chk(bias, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			r3 = (k == 3) ? 8'hFF : 8'($urandom);
			r4 = 8'($urandom);
			r5 = 8'($urandom);
			r5[5:4] = k[1:0];
			wr(ADDR_BIAS_TRIM, r3);
			wr(ADDR_ZERO_OFFSET, r4);
			wr(ADDR_AXIS_TRIM, r5);
			rd(ADDR_BIAS_TRIM, r3);
			rd(ADDR_ZERO_OFFSET, r4);
			rd(ADDR_AXIS_TRIM, msk(ADDR_AXIS_TRIM, r5));
			chk(bias, {r5[AXIS_X_BIT] ? r3 : 8'h00, r5[AXIS_Y_BIT] ? r3 : 8'h00});
		end
		u_mst.xfer({4'hF, ADDR_ZERO_OFFSET, ~r4}, rx);
		chk({8'h00, rx[7:0]}, {8'h00, rx[15:8]});
		repeat (12) @(posedge clk);
		rd(ADDR_ZERO_OFFSET, r4);
		rd(4'h7, 8'h00);
		fork
			wr(ADDR_FUSE_FLASH, 8'hFF);
			burn(4'h1, r3);
		join
		rd(ADDR_FUSE_FLASH, msk(ADDR_FUSE_FLASH, 8'hFF));
		fork
			wr(ADDR_FUSE_FLASH, 8'h10);
			burn(4'h2, r4);
		join
		v = 8'($urandom);
		fuse_values = {8'h00, v, 16'h0000};
		fuse_blown = 4'h2;
		rst();
		rd(ADDR_ZERO_OFFSET, v);
		wr(ADDR_ZERO_OFFSET, ~v);
		rd(ADDR_ZERO_OFFSET, v);
		rd(ADDR_BIAS_TRIM, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
